// ### core/sfr_pkg.sv
/*
 * constants, field layout and carrier types of the special-function
 * register bank; assumes a 200 MHz system clock
 */
`default_nettype none
package sfr_pkg;
   // clock and start-up timing
   localparam int CLK_MHZ        = 200;
   localparam int OST_TIME_MS    = 18;
   localparam int OST_CYCLES_DEF = OST_TIME_MS * 1000 * CLK_MHZ;

   // bus geometry; word index = address[5:2]
   localparam int ADDR_W = 6;
   localparam int DATA_W = 32;
   localparam logic [3:0] IDX_STATUS = 4'h0;
   localparam logic [3:0] IDX_RAMPTR = 4'h1;
   localparam logic [3:0] IDX_IRQFLG = 4'h2;
   localparam logic [3:0] IDX_TCTL   = 4'h3;
   localparam logic [3:0] IDX_DIR5   = 4'h4;
   localparam logic [3:0] IDX_WAKE6  = 4'h7;
   localparam logic [3:0] IDX_WWCTL  = 4'h8;
   localparam logic [3:0] IDX_MASK   = 4'h9;
   localparam int NUM_DIR = 3;

   // cpu_status fields
   localparam int ST_CARRY = 0;
   localparam int ST_HALF  = 1;
   localparam int ST_ZERO  = 2;
   localparam int ST_PD    = 3;
   localparam int ST_TO    = 4;
   localparam int ST_PAGE  = 5;
   localparam logic [7:0] ST_WR_MASK   = 8'he7;
   localparam logic [7:0] ST_PAGE_MASK = 8'h60;
   localparam logic [7:0] ST_POR       = 8'h18;
   localparam int PAGE_LOG2 = 10;

   // ram_bank_pointer fields
   localparam int RAM_BANK = 6;
   localparam logic [7:0] RAM_BANK_MASK = 8'hc0;

   // irq_flags / irq_mask fields
   localparam int IRQ_TIMER = 0;
   localparam int IRQ_EXT   = 3;
   localparam logic [7:0] IRQ_IMPL = 8'h09;

   // timer_control fields
   localparam int TC_PULLUP_N = 7;
   localparam int TC_GIE      = 6;
   localparam int TC_SRC      = 5;
   localparam int TC_EDGE     = 4;
   localparam int TC_PSA      = 3;
   localparam int TC_RATIO    = 0;
   localparam logic [7:0] TCTL_RST = 8'hbf;

   // wakeup_watchdog_control fields
   localparam int WW_P7WAKE_N = 0;
   localparam int WW_ROPT     = 3;
   localparam int WW_SLEEP2   = 4;
   localparam int WW_WDOG     = 5;
   localparam int WW_ODRAIN   = 6;
   localparam logic [7:0] WW_IMPL = 8'h79;
   localparam logic [7:0] WW_RST  = 8'h31;

   localparam logic [7:0] ONES_RST = 8'hff;

   typedef struct packed {
      logic              read;
      logic              write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
   } av_req_t;

   typedef struct packed {
      logic sleep_instruction;
      logic watchdog_clear_instruction;
      logic watchdog_timeout;
      logic irq_enable_instruction;
      logic irq_disable_instruction;
      logic irq_return_instruction;
      logic irq_taken;
      logic alu_flags_we;
      logic alu_zero;
      logic alu_half_carry;
      logic alu_carry;
      logic timer_overflow;
   } core_evt_t;

   typedef struct packed {
      logic       timer_source_select;
      logic       timer_edge_select;
      logic       prescaler_assign;
      logic [3:0] timer_ratio_log2;
      logic [3:0] watchdog_ratio_log2;
   } timer_cfg_t;

   typedef enum logic [1:0] {PWR_RUN, PWR_ASLEEP, PWR_WARMUP} pwr_state_t;
endpackage : sfr_pkg
`default_nettype wire

// ### core/startup_timer.sv
/*
 * oscillator start-up delay counter: a start pulse holds busy for
 * CYCLES clocks; assumes start only comes while idle
 */
`timescale 1ns/1ps
`default_nettype none
module startup_timer #(
   parameter int unsigned CYCLES = 16
) (
   input  wire logic clk_sys,
   input  wire logic reset,
   input  wire logic start,
   output var  logic busy
);
   localparam int CW = $clog2(CYCLES + 1);

   logic [CW-1:0] cnt_q;

   // a zero-length delay would never show busy
   if (CYCLES < 1) begin : g_chk
      $error("startup_timer: CYCLES must be at least 1");
   end

   // load on start, count down to zero
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         cnt_q <= '0;
      end else if (start) begin
         cnt_q <= CW'(CYCLES);
      end else if (cnt_q != '0) begin
         cnt_q <= cnt_q - CW'(1);
      end
   end

   assign busy = (cnt_q != '0);
endmodule : startup_timer
`default_nettype wire

// ### core/sfr_bank.sv
/*
 * special-function register bank of an 8-bit controller core:
 * status, page select, ram pointer, interrupt flags and mask,
 * timer control, port direction and wake-up / watchdog control.
 * assumes an avalon-mm master on clk_sys, core event pulses one
 * cycle wide and pin inputs already synchronous to clk_sys.
 */
// Operation
// - page bits pick 1k-word program page
// - returns never alter page select bits
// - timeout bit: set sleep/clear/power-up, cleared timeout
// - power-down bit: set power-on/clear, cleared sleep
// - zero, half carry, carry flags in status
// - pointer bits 7-6 select ram bank
// - pointer bits 5-0 give indirect address
// - external pin falling edge sets sticky flag
// - timer overflow sets sticky flag
// - software only clears flags; unused bits zero
// - flag read returns flags and mask
// - bit 7 low enables port pull-ups
// - bit 6 global enable, instructions and taking
// - timer source and edge select bits
// - bit 3 gives prescaler to watchdog
// - ratio field doubles timer and watchdog rates
// - direction bit 0 output, 1 high impedance
// - wake enables are active low, per pin on port 6, one bit for both port 7 pins
// - bit 6 makes port 7 high pins open-drain
// - watchdog enable obeys bit only if fuse 0
// - sleep-2 stops oscillator; wake waits start-up
// - mask bits enable external and timer flags
// - reset sets control ones except global enable and wake/watchdog bits 3 and 6
`timescale 1ns/1ps
`default_nettype none
module sfr_bank
   import sfr_pkg::*;
#(
   parameter int unsigned OST_CYCLES = OST_CYCLES_DEF
) (
   input  wire logic              clk_sys,
   input  wire logic              reset,
   input  wire logic              power_on_flag,
   input  wire av_req_t           av,
   output var  logic [DATA_W-1:0] readdata,
   output var  logic              waitrequest,
   input  wire core_evt_t         evt,
   input  wire logic              ext_irq_pin,
   input  wire logic [7:0]        port6_pins,
   input  wire logic [1:0]        port7_wake_pins,
   input  wire logic              fuse_watchdog_option,
   output var  logic [11:0]       prog_page_base,
   output var  logic [1:0]        ram_bank,
   output var  logic [5:0]        indirect_addr,
   output var  timer_cfg_t        timer_cfg,
   output var  logic              pullup_enable_n,
   output var  logic [7:0]        port5_dir,
   output var  logic [7:0]        port6_dir,
   output var  logic [7:0]        port7_dir,
   output var  logic [7:0]        port6_wake_enable_n,
   output var  logic              port7_wake_enable_n,
   output var  logic              open_drain_enable,
   output var  logic              resistor_option_enable,
   output var  logic              watchdog_active,
   output var  logic              irq_request,
   output var  logic              osc_enable,
   output var  logic              core_hold
);
   logic [7:0] status_q;
   logic [7:0] ramptr_q;
   logic [7:0] flags_q;
   logic [7:0] mask_q;
   logic [7:0] tctl_q;
   logic [7:0] dir_q [NUM_DIR];
   logic [7:0] wake6_q;
   logic [7:0] ww_q;
   logic       ack_q;
   logic       ext_pin_q;
   logic [7:0] rd_byte;
   logic [3:0] idx;
   logic       wr_en;
   logic       ext_fall;
   logic       wake_hit;
   logic       ost_start;
   logic       ost_busy;
   pwr_state_t pwr_q;
   logic [7:0] flag_set;

   // bus handshake: every access waits exactly one cycle
   assign idx         = av.address[5:2];
   assign waitrequest = (av.read | av.write) & ~ack_q;
   assign wr_en       = av.write & ack_q;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (av.read | av.write) & ~ack_q;
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      unique case (idx)
         IDX_STATUS: rd_byte = status_q;
         IDX_RAMPTR: rd_byte = ramptr_q;
         IDX_IRQFLG: rd_byte = flags_q & mask_q & IRQ_IMPL;
         IDX_TCTL:   rd_byte = tctl_q;
         IDX_WAKE6:  rd_byte = wake6_q;
         IDX_WWCTL:  rd_byte = ww_q & WW_IMPL;
         IDX_MASK:   rd_byte = mask_q & IRQ_IMPL;
         default: begin
            if (idx >= IDX_DIR5 && idx < IDX_DIR5 + 4'(NUM_DIR)) begin
               rd_byte = dir_q[2'(idx - IDX_DIR5)];
            end
         end
      endcase
   end

   // read data captured while waitrequest is high, stands after
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         readdata <= '0;
      end else if (av.read & ~ack_q) begin
         readdata <= {{(DATA_W - 8){1'b0}}, rd_byte};
      end
   end

   // status: page bits survive non-power-on resets
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         if (power_on_flag) begin
            status_q <= ST_POR;
         end
         if (evt.watchdog_timeout) begin
            status_q[ST_TO] <= 1'b0;
         end
      end else begin
         if (wr_en && idx == IDX_STATUS) begin
            status_q <= (status_q & ~ST_WR_MASK) | (av.writedata[7:0] & ST_WR_MASK);
         end
         if (evt.alu_flags_we) begin
            status_q[ST_ZERO]  <= evt.alu_zero;
            status_q[ST_HALF]  <= evt.alu_half_carry;
            status_q[ST_CARRY] <= evt.alu_carry;
         end
         if (evt.sleep_instruction | evt.watchdog_clear_instruction) begin
            status_q[ST_TO] <= 1'b1;
         end
         if (evt.watchdog_timeout) begin
            status_q[ST_TO] <= 1'b0;
         end
         if (evt.watchdog_clear_instruction) begin
            status_q[ST_PD] <= 1'b1;
         end else if (evt.sleep_instruction) begin
            status_q[ST_PD] <= 1'b0;
         end
      end
   end

   assign prog_page_base = {status_q[ST_PAGE+1:ST_PAGE], {PAGE_LOG2{1'b0}}};

   // ram pointer; only power-on clears the bank bits
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         if (power_on_flag) begin
            ramptr_q <= ramptr_q & ~RAM_BANK_MASK;
         end
      end else if (wr_en && idx == IDX_RAMPTR) begin
         ramptr_q <= av.writedata[7:0];
      end
   end

   assign ram_bank      = ramptr_q[RAM_BANK+1:RAM_BANK];
   assign indirect_addr = ramptr_q[5:0];

   // inputs are synchronous, one stage is enough for edges
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ext_pin_q <= 1'b1;
      end else begin
         ext_pin_q <= ext_irq_pin;
      end
   end

   // falling edge of the external pin
   assign ext_fall = ext_pin_q & ~ext_irq_pin;

   always_comb begin
      flag_set            = 8'h00;
      flag_set[IRQ_EXT]   = ext_fall;
      flag_set[IRQ_TIMER] = evt.timer_overflow;
   end

   // writes only clear, a same-cycle event wins
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         flags_q <= 8'h00;
      end else if (wr_en && idx == IDX_IRQFLG) begin
         flags_q <= (flags_q & av.writedata[7:0] & IRQ_IMPL) | flag_set;
      end else begin
         flags_q <= flags_q | flag_set;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mask_q <= 8'h00;
      end else if (wr_en && idx == IDX_MASK) begin
         mask_q <= av.writedata[7:0] & IRQ_IMPL;
      end
   end

   // global enable: clearing wins over setting
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         tctl_q <= TCTL_RST;
      end else begin
         if (wr_en && idx == IDX_TCTL) begin
            tctl_q <= av.writedata[7:0];
         end
         if (evt.irq_disable_instruction | evt.irq_taken) begin
            tctl_q[TC_GIE] <= 1'b0;
         end else if (evt.irq_enable_instruction | evt.irq_return_instruction) begin
            tctl_q[TC_GIE] <= 1'b1;
         end
      end
   end

   assign pullup_enable_n = tctl_q[TC_PULLUP_N];

   always_comb begin
      timer_cfg.timer_source_select = tctl_q[TC_SRC];
      timer_cfg.timer_edge_select   = tctl_q[TC_EDGE];
      timer_cfg.prescaler_assign    = tctl_q[TC_PSA];
      timer_cfg.timer_ratio_log2    = {1'b0, tctl_q[TC_RATIO+2:TC_RATIO]} + 4'h1;
      timer_cfg.watchdog_ratio_log2 = {1'b0, tctl_q[TC_RATIO+2:TC_RATIO]};
   end

   // one direction register per port, all input at reset
   for (genvar p = 0; p < NUM_DIR; p++) begin : g_dir
      always_ff @(posedge clk_sys) begin
         if (reset) begin
            dir_q[p] <= ONES_RST;
         end else if (wr_en && idx == IDX_DIR5 + 4'(p)) begin
            dir_q[p] <= av.writedata[7:0];
         end
      end
   end

   assign port5_dir = dir_q[0];
   assign port6_dir = dir_q[1];
   assign port7_dir = dir_q[2];

   // port 6 wake enables, all disabled at reset
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         wake6_q <= ONES_RST;
      end else if (wr_en && idx == IDX_WAKE6) begin
         wake6_q <= av.writedata[7:0];
      end
   end

   assign port6_wake_enable_n = wake6_q;
   assign port7_wake_enable_n = ww_q[WW_P7WAKE_N];

   // low pin with its enable low wakes the core
   assign wake_hit = (|(~port6_pins & ~wake6_q))
                   | (|(~port7_wake_pins & {2{~ww_q[WW_P7WAKE_N]}}));

   // hardware sets the sleep-2 bit on wake, over a write
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ww_q <= WW_RST;
      end else begin
         if (wr_en && idx == IDX_WWCTL) begin
            ww_q <= av.writedata[7:0] & WW_IMPL;
         end
         if (pwr_q == PWR_ASLEEP && wake_hit) begin
            ww_q[WW_SLEEP2] <= 1'b1;
         end
      end
   end

   // open-drain for port 7 high pins
   assign open_drain_enable      = ww_q[WW_ODRAIN];
   assign resistor_option_enable = ww_q[WW_ROPT];
   // fuse set keeps the watchdog off
   assign watchdog_active = ~fuse_watchdog_option & ww_q[WW_WDOG];

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pwr_q <= PWR_RUN;
      end else begin
         unique case (pwr_q)
            PWR_RUN: begin
               if (!ww_q[WW_SLEEP2]) begin
                  pwr_q <= PWR_ASLEEP;
               end
            end
            PWR_ASLEEP: begin
               if (wake_hit) begin
                  pwr_q <= PWR_WARMUP;
               end
            end
            PWR_WARMUP: begin
               if (!ost_busy && !ost_start) begin
                  pwr_q <= PWR_RUN;
               end
            end
         endcase
      end
   end

   assign ost_start  = (pwr_q == PWR_ASLEEP) && wake_hit;
   assign osc_enable = (pwr_q != PWR_ASLEEP);
   // core may not execute until the oscillator has settled
   assign core_hold  = (pwr_q != PWR_RUN);

   startup_timer #(
      .CYCLES (OST_CYCLES)
   ) u_ost (
      .clk_sys (clk_sys),
      .reset   (reset),
      .start   (ost_start),
      .busy    (ost_busy)
   );

   // request gated by flag, mask and global enable
   assign irq_request = (|(flags_q & mask_q & IRQ_IMPL)) & tctl_q[TC_GIE];

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   sequence s_rd_flags;
      av.read && !ack_q && idx == IDX_IRQFLG;
   endsequence

   sequence s_sleep_wake;
      pwr_q == PWR_ASLEEP && wake_hit;
   endsequence

   property p_page_hold;
      evt.irq_return_instruction && !(wr_en && idx == IDX_STATUS)
         |=> $stable(prog_page_base);
   endproperty
   a_page_hold: assert property (p_page_hold) else $error("page moved on return");

   property p_to_set;
      (evt.sleep_instruction || evt.watchdog_clear_instruction) && !evt.watchdog_timeout
         |=> status_q[ST_TO];
   endproperty
   a_to_set: assert property (p_to_set) else $error("timeout bit not set");

   property p_pd_clr;
      evt.sleep_instruction && !evt.watchdog_clear_instruction |=> !status_q[ST_PD];
   endproperty
   a_pd_clr: assert property (p_pd_clr) else $error("power-down bit not cleared");

   property p_ext_flag;
      ext_pin_q && !ext_irq_pin
         |=> flags_q[IRQ_EXT] ##1 (flags_q[IRQ_EXT] || $past(wr_en && idx == IDX_IRQFLG));
   endproperty
   a_ext_flag: assert property (p_ext_flag) else $error("external flag lost");

   property p_no_set;
      wr_en && idx == IDX_IRQFLG && flag_set == 8'h00 |=> (flags_q & ~$past(flags_q)) == 8'h00;
   endproperty
   a_no_set: assert property (p_no_set) else $error("write set a flag");

   property p_rd_flags;
      s_rd_flags ##1 !waitrequest |-> readdata[7:0] == ($past(flags_q) & $past(mask_q));
   endproperty
   a_rd_flags: assert property (p_rd_flags) else $error("flag read not masked");

   property p_gie_clr;
      evt.irq_taken |=> !tctl_q[TC_GIE] && !irq_request;
   endproperty
   a_gie_clr: assert property (p_gie_clr) else $error("global enable stayed");

   property p_wdog;
      fuse_watchdog_option |-> !watchdog_active;
   endproperty
   a_wdog: assert property (p_wdog) else $error("watchdog on despite fuse");

   property p_wake;
      s_sleep_wake |=> ww_q[WW_SLEEP2] && core_hold && osc_enable ##1 ost_busy;
   endproperty
   a_wake: assert property (p_wake) else $error("wake sequence wrong");

   property p_reset_val;
      $fell(reset) |-> tctl_q == TCTL_RST && wake6_q == ONES_RST && ww_q == WW_RST;
   endproperty
   a_reset_val: assert property (p_reset_val) else $error("bad reset values");

   property p_irq_req;
      irq_request |-> tctl_q[TC_GIE] && (flags_q & mask_q) != 8'h00;
   endproperty
   a_irq_req: assert property (p_irq_req) else $error("request without cause");
endmodule : sfr_bank
`default_nettype wire

// ### sim/core_model.sv
/*
 * model of the processor core on the far side of the register bank:
 * an avalon-mm master and one-cycle event pulses.
 * assumes the bank answers on clk_sys and drives waitrequest combinationally.
 */
`timescale 1ns/1ps
`default_nettype none
module core_model
   import sfr_pkg::*;
(
   input  wire logic              clk_sys,
   input  wire logic              waitrequest,
   input  wire logic [DATA_W-1:0] readdata,
   output var  av_req_t           av,
   output var  core_evt_t         evt
);
   // idle bus and no events at time zero
   initial begin
      av  = '0;
      evt = '0;
   end

   // one bus cycle; the request stands until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d,
                      output logic [DATA_W-1:0] q);
      @(posedge clk_sys);
      av <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}};
      do @(posedge clk_sys); while (waitrequest !== 1'b0);
      q = readdata;
      // released lines flip so a stale address or data cannot pass for a valid one
      av <= '{read: 1'b0, write: 1'b0, address: ~a, writedata: ~{24'h0, d}};
   endtask : bus

   // one-cycle event pulse, as an executing instruction would give it
   task automatic pulse(input core_evt_t e);
      @(posedge clk_sys);
      evt <= e;
      @(posedge clk_sys);
      evt <= '0;
   endtask : pulse
endmodule : core_model
`default_nettype wire

// ### sim/sfr_bank_tb.sv
/*
 * self-checking bench of the special-function register bank.
 * assumes the core model as bus master and short start-up timing.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check(32'(g), 32'(e), `__LINE__)
module sfr_bank_tb;
   import sfr_pkg::*;
   localparam int unsigned OSCILLATOR_STARTUP_TIMER = 20;
   logic              clk_sys, reset, power_on_flag, ext_irq_pin, fuse_watchdog_option;
   logic [7:0]        port6_pins, port5_dir, port6_dir, port7_dir, port6_wake_enable_n;
   logic [1:0]        port7_wake_pins, ram_bank;
   av_req_t           av;
   core_evt_t         evt;
   logic [DATA_W-1:0] readdata;
   logic [11:0]       prog_page_base;
   logic [5:0]        indirect_addr;
   timer_cfg_t        timer_cfg;
   logic              waitrequest, pullup_enable_n, port7_wake_enable_n, open_drain_enable;
   logic              resistor_option_enable, watchdog_active, irq_request, osc_enable, core_hold;
   int                bad_count, cmp_count;

   sfr_bank #(.OST_CYCLES(OSCILLATOR_STARTUP_TIMER)) sfr_bank_i (.clk_sys, .reset, .power_on_flag, .av, .readdata,
      .waitrequest, .evt, .ext_irq_pin, .port6_pins, .port7_wake_pins, .fuse_watchdog_option,
      .prog_page_base, .ram_bank, .indirect_addr, .timer_cfg, .pullup_enable_n, .port5_dir,
      .port6_dir, .port7_dir, .port6_wake_enable_n, .port7_wake_enable_n, .open_drain_enable,
      .resistor_option_enable, .watchdog_active, .irq_request, .osc_enable, .core_hold);
   core_model core_model_i (.clk_sys, .waitrequest, .readdata, .av, .evt);

   // 200 mhz clock
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   task automatic check(input logic [31:0] g, input logic [31:0] e, input int ln);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h want %h line %0d", $time, g, e, ln);
      end
   endtask : check

   task automatic report_and_stop();
      $display("compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop

   // bus helpers; outputs are looked at on the falling edge once updates have landed
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic [31:0] q;
      core_model_i.bus(1'b1, a, d, q);
      @(negedge clk_sys);
   endtask : wr

   task automatic chk_rd(input logic [5:0] a, input logic [31:0] e);
      logic [31:0] q;
      core_model_i.bus(1'b0, a, 8'h00, q);
      `CHK(q, e);
   endtask : chk_rd

   task automatic ev(input core_evt_t e);
      core_model_i.pulse(e);
      @(negedge clk_sys);
   endtask : ev

   task automatic t_reset();
      chk_rd(6'h00, 32'h18);
      chk_rd(6'h0c, 32'hbf);
      for (int i = 0; i < 3; i++) chk_rd(6'(6'h10 + 4 * i), 32'hff);
      chk_rd(6'h1c, 32'hff);
      chk_rd(6'h20, 32'h31);
      chk_rd(6'h08, 32'h00);
      chk_rd(6'h24, 32'h00);
      `CHK({pullup_enable_n, port6_wake_enable_n}, 9'h1ff);
      $display("test reset values done");
   endtask : t_reset

   task automatic t_status();
      for (int p = 0; p < 4; p++) begin
         wr(6'h00, 8'(p << 5));
         `CHK(prog_page_base, p << 10);
      end
      ev('{irq_return_instruction: 1'b1, default: 1'b0});
      `CHK(prog_page_base, 12'hc00);
      wr(6'h00, 8'h00);
      chk_rd(6'h00, 32'h18);
      wr(6'h00, 8'hff);
      ev('{sleep_instruction: 1'b1, default: 1'b0});
      chk_rd(6'h00, 32'hf7);
      ev('{watchdog_timeout: 1'b1, default: 1'b0});
      chk_rd(6'h00, 32'he7);
      ev('{watchdog_clear_instruction: 1'b1, default: 1'b0});
      chk_rd(6'h00, 32'hff);
      wr(6'h00, 8'h00);
      ev('{alu_flags_we: 1'b1, alu_zero: 1'b1, alu_carry: 1'b1, default: 1'b0});
      chk_rd(6'h00, 32'h1d);
      ev('{alu_flags_we: 1'b1, alu_half_carry: 1'b1, default: 1'b0});
      chk_rd(6'h00, 32'h1a);
      $display("test status done");
   endtask : t_status

   task automatic t_ptr();
      wr(6'h04, 8'ha5);
      `CHK({ram_bank, indirect_addr}, 8'ha5);
      wr(6'h04, 8'h7e);
      `CHK({ram_bank, indirect_addr}, 8'h7e);
      chk_rd(6'h04, 32'h7e);
      $display("test ram pointer done");
   endtask : t_ptr

   task automatic t_irq();
      ev('{irq_disable_instruction: 1'b1, default: 1'b0});
      wr(6'h24, 8'h09);
      ev('{timer_overflow: 1'b1, default: 1'b0});
      `CHK(irq_request, 1'b0);
      chk_rd(6'h08, 32'h01);
      @(posedge clk_sys);
      ext_irq_pin <= 1'b0;
      repeat (2) @(posedge clk_sys);
      ext_irq_pin <= 1'b1;
      chk_rd(6'h08, 32'h09);
      ev('{irq_enable_instruction: 1'b1, default: 1'b0});
      `CHK(irq_request, 1'b1);
      chk_rd(6'h0c, 32'hff);
      ev('{irq_taken: 1'b1, default: 1'b0});
      `CHK(irq_request, 1'b0);
      ev('{irq_return_instruction: 1'b1, default: 1'b0});
      `CHK(irq_request, 1'b1);
      wr(6'h24, 8'h01);
      chk_rd(6'h08, 32'h01);
      wr(6'h24, 8'h00);
      `CHK(irq_request, 1'b0);
      wr(6'h24, 8'h09);
      wr(6'h08, 8'h00);
      `CHK(irq_request, 1'b0);
      wr(6'h08, 8'hff);
      chk_rd(6'h08, 32'h00);
      ev('{irq_disable_instruction: 1'b1, default: 1'b0});
      $display("test interrupts done");
   endtask : t_irq

   task automatic t_timer();
      logic [2:0] r;
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         r = 3'(i);
         d = {2'b00, r[0], ~r[0], r[1], r};
         wr(6'h0c, d);
         `CHK(timer_cfg, {r[0], ~r[0], r[1], 4'(i + 1), 4'(i)});
         `CHK(pullup_enable_n, 1'b0);
         chk_rd(6'h0c, {24'h0, d});
      end
      $display("test timer control done");
   endtask : t_timer

   task automatic t_ports();
      for (int i = 0; i < 3; i++) wr(6'(6'h10 + 4 * i), 8'(8'h5a + i));
      `CHK({port5_dir, port6_dir, port7_dir}, 24'h5a5b5c);
      chk_rd(6'h18, 32'h5c);
      wr(6'h20, 8'h71);
      `CHK({open_drain_enable, watchdog_active, port7_wake_enable_n, resistor_option_enable}, 4'b1110);
      @(posedge clk_sys);
      fuse_watchdog_option <= 1'b1;
      @(negedge clk_sys);
      `CHK(watchdog_active, 1'b0);
      @(posedge clk_sys);
      fuse_watchdog_option <= 1'b0;
      wr(6'h20, 8'h18);
      `CHK({open_drain_enable, watchdog_active, port7_wake_enable_n, resistor_option_enable}, 4'b0001);
      wr(6'h20, 8'hff);
      chk_rd(6'h20, 32'h79);
      wr(6'h28, 8'hff);
      chk_rd(6'h28, 32'h00);
      wr(6'h1c, 8'h5a);
      `CHK(port6_wake_enable_n, 8'h5a);
      $display("test ports and wake-up done");
   endtask : t_ports

   task automatic t_sleep2();
      int n;
      wr(6'h1c, 8'hfe);
      wr(6'h20, 8'h61);
      @(negedge clk_sys);
      `CHK({osc_enable, core_hold}, 2'b01);
      // a disabled pin must not wake the core
      @(posedge clk_sys);
      port6_pins <= 8'hfd;
      repeat (3) @(negedge clk_sys);
      `CHK({osc_enable, core_hold}, 2'b01);
      @(posedge clk_sys);
      port6_pins <= 8'hfe;
      n = 0;
      repeat (2) @(negedge clk_sys);
      `CHK({osc_enable, core_hold}, 2'b11);
      while (core_hold === 1'b1 && n < OSCILLATOR_STARTUP_TIMER + 10) begin
         @(negedge clk_sys);
         n++;
      end
      `CHK(n >= OSCILLATOR_STARTUP_TIMER - 2 && n <= OSCILLATOR_STARTUP_TIMER + 3, 1'b1);
      @(posedge clk_sys);
      port6_pins <= 8'hff;
      chk_rd(6'h20, 32'h71);
      // port 7 wake pins, enabled by bit 0 low, wake a second sleep
      wr(6'h20, 8'h60);
      @(posedge clk_sys);
      port7_wake_pins <= 2'b01;
      repeat (2) @(negedge clk_sys);
      `CHK({osc_enable, core_hold}, 2'b11);
      $display("test sleep 2 done");
   endtask : t_sleep2

   // hang guard, well past the few hundred cycles the tests need
   initial begin
      #50us;
      bad_count++;
      report_and_stop();
   end

   // power-on reset for three cycles, then the tests in turn
   initial begin
      bad_count = 0;
      cmp_count = 0;
      reset = 1'b1;
      power_on_flag = 1'b1;
      ext_irq_pin = 1'b1;
      fuse_watchdog_option = 1'b0;
      port6_pins = 8'hff;
      port7_wake_pins = 2'b11;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      power_on_flag <= 1'b0;
      t_reset();
      t_status();
      t_ptr();
      t_irq();
      t_timer();
      t_ports();
      t_sleep2();
      report_and_stop();
   end
endmodule : sfr_bank_tb
`default_nettype wire
